/* File: rtl/eph_pkg.sv */
// Constants, register map and state type for the Ethernet PHY bring-up block
package eph_pkg;
	// Management frame fields
	localparam logic [4:0]  PHY_ADDR   = 5'h01;
	localparam logic [1:0]  FRM_START  = 2'h1;
	localparam logic [1:0]  OP_READ    = 2'h2;
	localparam logic [1:0]  OP_WRITE   = 2'h1;
	localparam logic [3:0]  HDR_LAST   = 4'hC;
	localparam logic [3:0]  TA_LAST    = 4'h1;
	localparam logic [3:0]  DATA_LAST  = 4'hF;
	// Register addresses
	localparam logic [4:0]  REG_CTRL   = 5'h00;
	localparam logic [4:0]  REG_STAT   = 5'h01;
	localparam logic [4:0]  REG_ID1    = 5'h02;
	localparam logic [4:0]  REG_ID2    = 5'h03;
	localparam logic [4:0]  REG_ADV    = 5'h04;
	localparam logic [4:0]  REG_GADV   = 5'h09;
	localparam logic [4:0]  REG_DLY    = 5'h19;
	// Field positions
	localparam int          CTRL_RESET_B   = 15;
	localparam int          CTRL_SPD0_B    = 13;
	localparam int          CTRL_ANEN_B    = 12;
	localparam int          CTRL_RESTART_B = 9;
	localparam int          CTRL_SPD1_B    = 6;
	localparam int          STAT_ANC_B     = 5;
	localparam int          STAT_LINK_B    = 2;
	localparam int          ADV_100_B      = 8;
	localparam int          ADV_100H_B     = 7;
	localparam int          GADV_1000F_B   = 9;
	// Values after reset
	localparam logic [15:0] STAT_CAPS  = 16'h7909;
	localparam logic [15:0] ADV_RST    = 16'h01E1;
	localparam logic [15:0] GADV_RST   = 16'h0200;
	localparam logic [1:0]  DLY_RST    = 2'h3;
	localparam logic [15:0] ID1_VAL    = 16'h1234; // Arbitrary value
	localparam logic [15:0] ID2_VAL    = 16'h5670; // Arbitrary value
	// Identifier storage
	localparam logic [7:0]  OTP_ID_BASE = 8'h20;
	localparam logic [7:0]  OTP_ID_LAST = 8'h25;
	localparam logic [7:0]  OTP_BLANK   = 8'hFF;
	// Timing
	localparam int CLK_HZ     = 20000000;
	localparam int ANEG_US    = 1000;
	localparam int EEE_ON_MS  = 400;
	localparam int EEE_OFF_MS = 2000;
	localparam int ACT_MS     = 50;
	localparam int ANEG_CYC    = CLK_HZ / 1000000 * ANEG_US;
	localparam int EEE_ON_CYC  = CLK_HZ / 1000 * EEE_ON_MS;
	localparam int EEE_OFF_CYC = CLK_HZ / 1000 * EEE_OFF_MS;
	localparam int ACT_CYC     = CLK_HZ / 1000 * ACT_MS;
	// Link speed codes
	localparam logic [1:0] SPD_10   = 2'h0;
	localparam logic [1:0] SPD_100  = 2'h1;
	localparam logic [1:0] SPD_1000 = 2'h2;

	typedef enum logic [1:0] {
		MST_IDLE = 2'b00,
		MST_HDR  = 2'b01,
		MST_TA   = 2'b10,
		MST_DATA = 2'b11
	} eph_mst_t;
endpackage

/* File: rtl/eph_phy_core.sv */
// Ethernet PHY bring-up: management slave, link, indicators, identifier
`timescale 1ns/10ps
module eph_phy_core #(
	parameter int          ANEG_CYC    = eph_pkg::ANEG_CYC,
	parameter int          EEE_ON_CYC  = eph_pkg::EEE_ON_CYC,
	parameter int          EEE_OFF_CYC = eph_pkg::EEE_OFF_CYC,
	parameter int          ACT_CYC     = eph_pkg::ACT_CYC,
	parameter logic [47:0] MAC_ID      = 48'h0200000000A5 // Arbitrary value
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       srst,
	// Host GPIO lines
	input  wire logic       phy_reset_line_n,
	output logic            phy_irq_line_n,
	// Management bus
	input  wire logic       mdc,
	input  wire logic       mdio_in,
	output logic            mdio_out,
	output logic            mdio_oe,
	// Line side
	input  wire logic       partner_present,
	input  wire logic       partner_eee,
	// RGMII frame activity
	input  wire logic       rgmii_rx_dv,
	input  wire logic       rgmii_tx_en,
	// Status and configuration
	output logic            link_up,
	output logic            an_done,
	output logic [1:0]      link_speed,
	output logic            rgmii_txc_delay_en,
	output logic            rgmii_rxc_delay_en,
	output logic            led_link,
	output logic            led_act,
	// Identifier storage
	input  wire logic [7:0] otp_addr,
	output logic [7:0]      otp_data
);
	logic             rstn_s1, rstn_s2, rst;
	logic             mdc_s1, mdc_s2, mdc_s3, mdio_s1, mdio_s2;
	logic             prt_s1, prt_s2, eee_s1, eee_s2;
	logic [1:0]       act_s1, act_s2;
	logic             mdc_rise, mdc_fall;
	eph_pkg::eph_mst_t st;
	logic [3:0]       cnt;
	logic [13:0]      hdr;
	logic [13:0]      hv;
	logic [15:0]      wsh, wdat;
	logic [16:0]      rd_sh;
	logic [4:0]       reg_a;
	logic             mine, is_rd, rd_act, wr_stb, rd_done;
	logic [15:0]      rd_val;
	logic             an_en, an_restart, link_q, stat_ll;
	logic [1:0]       frc_spd;
	logic [15:0]      adv, gadv;
	logic [25:0]      aneg_cnt, eee_cnt, act_cnt;
	logic             act_pend;
	logic [7:0]       next_otp;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Pin reset is asynchronous to clk, so it is synchronised first
	always_ff @(posedge clk) begin
		if (srst) begin
			rstn_s1 <= 1'b0;
			rstn_s2 <= 1'b0;
		end else begin
			rstn_s1 <= phy_reset_line_n;
			rstn_s2 <= rstn_s1;
		end
	end
	assign rst = srst | ~rstn_s2;

	// Bus, line and activity pins pass two flops (otp_addr does not); mdc needs a third for edge finding
	always_ff @(posedge clk) begin
		if (srst) begin
			{mdc_s1, mdc_s2, mdc_s3, mdio_s1, mdio_s2} <= 5'h00;
			{prt_s1, prt_s2, eee_s1, eee_s2, act_s1, act_s2} <= 8'h00;
		end else begin
			mdc_s1  <= mdc;
			mdc_s2  <= mdc_s1;
			mdc_s3  <= mdc_s2;
			mdio_s1 <= mdio_in;
			mdio_s2 <= mdio_s1;
			prt_s1  <= partner_present;
			prt_s2  <= prt_s1;
			eee_s1  <= partner_eee;
			eee_s2  <= eee_s1;
			// Each pin synchronised alone; no gate ahead of the first flop
			act_s1  <= {rgmii_rx_dv, rgmii_tx_en};
			act_s2  <= act_s1;
		end
	end
	assign mdc_rise = mdc_s2 & ~mdc_s3;
	assign mdc_fall = ~mdc_s2 & mdc_s3;
	assign hv = {hdr[12:0], mdio_s2};

	always_comb begin
		unique case (hv[4:0])
			eph_pkg::REG_CTRL: begin
				rd_val = 16'h0000;
				rd_val[eph_pkg::CTRL_ANEN_B] = an_en;
				rd_val[eph_pkg::CTRL_SPD0_B] = frc_spd[0];
				rd_val[eph_pkg::CTRL_SPD1_B] = frc_spd[1];
			end
			eph_pkg::REG_STAT: begin
				rd_val = eph_pkg::STAT_CAPS;
				rd_val[eph_pkg::STAT_LINK_B] = stat_ll;
				rd_val[eph_pkg::STAT_ANC_B] = an_done;
			end
			eph_pkg::REG_ID1: rd_val = eph_pkg::ID1_VAL;
			eph_pkg::REG_ID2: rd_val = eph_pkg::ID2_VAL;
			eph_pkg::REG_ADV: rd_val = adv;
			eph_pkg::REG_GADV: rd_val = gadv;
			eph_pkg::REG_DLY:
				rd_val = {14'h0000, rgmii_rxc_delay_en, rgmii_txc_delay_en};
			default: rd_val = 16'h0000;
		endcase
	end

	// Management frame slave: sample on mdc rise, drive on mdc fall
	always_ff @(posedge clk) begin
		if (rst) begin
			st <= eph_pkg::MST_IDLE;
			cnt <= 4'h0;
			hdr <= 14'h0000;
			wsh <= 16'h0000;
			wdat <= 16'h0000;
			rd_sh <= 17'h00000;
			reg_a <= 5'h00;
			{mine, is_rd, rd_act, wr_stb, rd_done} <= 5'h00;
			mdio_oe <= 1'b0;
			mdio_out <= 1'b0;
		end else begin
			wr_stb <= 1'b0;
			rd_done <= 1'b0;
			if (mdc_rise) begin
				cnt <= cnt + 4'h1;
				unique case (st)
					eph_pkg::MST_IDLE: begin
						// Preamble ones are skipped; the first zero is the start
						cnt <= 4'h0;
						hdr <= 14'h0000;
						if (!mdio_s2) begin
							st <= eph_pkg::MST_HDR;
						end
					end
					eph_pkg::MST_HDR: begin
						hdr <= hv;
						if (cnt == eph_pkg::HDR_LAST) begin
							mine <= hv[13:12] == eph_pkg::FRM_START &&
								hv[9:5] == eph_pkg::PHY_ADDR &&
								(hv[11:10] == eph_pkg::OP_READ ||
								 hv[11:10] == eph_pkg::OP_WRITE);
							is_rd <= hv[11:10] == eph_pkg::OP_READ;
							rd_act <= hv[13:12] == eph_pkg::FRM_START &&
								hv[9:5] == eph_pkg::PHY_ADDR &&
								hv[11:10] == eph_pkg::OP_READ;
							rd_sh <= {1'b0, rd_val};
							reg_a <= hv[4:0];
							st <= eph_pkg::MST_TA;
							cnt <= 4'h0;
						end
					end
					eph_pkg::MST_TA: begin
						if (cnt == eph_pkg::TA_LAST) begin
							st <= eph_pkg::MST_DATA;
							cnt <= 4'h0;
						end
					end
					eph_pkg::MST_DATA: begin
						wsh <= {wsh[14:0], mdio_s2};
						if (cnt == eph_pkg::DATA_LAST) begin
							st <= eph_pkg::MST_IDLE;
							rd_act <= 1'b0;
							wdat <= {wsh[14:0], mdio_s2};
							wr_stb <= mine & ~is_rd;
							rd_done <= mine & is_rd;
						end
					end
				endcase
			end
			// Own the line only from second turnaround bit to last data bit
			if (mdc_fall) begin
				if (rd_act && ((st == eph_pkg::MST_TA &&
					cnt == eph_pkg::TA_LAST) || st == eph_pkg::MST_DATA)) begin
					mdio_oe <= 1'b1;
					mdio_out <= rd_sh[16];
					rd_sh <= {rd_sh[15:0], 1'b0};
				end else begin
					mdio_oe <= 1'b0;
					mdio_out <= 1'b0;
				end
			end
		end
	end

	AST_FOREIGN_SILENT: assert property (
		(st inside {eph_pkg::MST_TA, eph_pkg::MST_DATA} && !mine) |-> !mdio_oe)
		else $error("PHY drove the bus for a foreign frame");
	AST_TA_ZERO: assert property (
		$rose(mdio_oe) |-> st == eph_pkg::MST_TA && !mdio_out)
		else $error("Read drive did not start with turnaround zero");
	COV_READ: cover property ($rose(mdio_oe));

	// Configuration registers; a soft reset restores an_en, adv and gadv only; speed takes the written bits
	always_ff @(posedge clk) begin
		if (rst) begin
			an_en <= 1'b1;
			an_restart <= 1'b0;
			frc_spd <= eph_pkg::SPD_1000;
			adv <= eph_pkg::ADV_RST;
			gadv <= eph_pkg::GADV_RST;
			{rgmii_rxc_delay_en, rgmii_txc_delay_en} <= eph_pkg::DLY_RST;
		end else begin
			an_restart <= 1'b0;
			if (wr_stb) begin
				unique case (reg_a)
					eph_pkg::REG_CTRL: begin
						if (wdat[eph_pkg::CTRL_RESET_B]) begin
							an_en <= 1'b1;
							adv <= eph_pkg::ADV_RST;
							gadv <= eph_pkg::GADV_RST;
							an_restart <= 1'b1;
						end else begin
							an_en <= wdat[eph_pkg::CTRL_ANEN_B];
							an_restart <= wdat[eph_pkg::CTRL_RESTART_B];
						end
						frc_spd <= {wdat[eph_pkg::CTRL_SPD1_B],
							wdat[eph_pkg::CTRL_SPD0_B]};
					end
					eph_pkg::REG_ADV: adv <= wdat;
					eph_pkg::REG_GADV: gadv <= wdat;
					eph_pkg::REG_DLY:
						{rgmii_rxc_delay_en, rgmii_txc_delay_en} <= wdat[1:0];
					default: ;
				endcase
			end
		end
	end

	AST_POWERUP_ADV: assert property (
		$fell(rst) |-> an_en && adv == eph_pkg::ADV_RST &&
			gadv[eph_pkg::GADV_1000F_B])
		else $error("Power-up advertisement wrong");
	AST_DLY_DEFAULT: assert property (
		$fell(rst) |-> rgmii_txc_delay_en && rgmii_rxc_delay_en)
		else $error("Clock delay not on after reset");

	// Link comes up without any host access once negotiation time passes
	always_ff @(posedge clk) begin
		if (rst) begin
			aneg_cnt <= 26'h0000000;
			link_up <= 1'b0;
			an_done <= 1'b0;
			link_speed <= eph_pkg::SPD_10;
		end else if (!prt_s2 || an_restart) begin
			aneg_cnt <= 26'h0000000;
			link_up <= 1'b0;
			an_done <= 1'b0;
		end else if (!an_en) begin
			link_up <= 1'b1;
			an_done <= 1'b0;
			link_speed <= frc_spd;
		end else if (!link_up) begin
			if (aneg_cnt == 26'(ANEG_CYC - 1)) begin
				link_up <= 1'b1;
				an_done <= 1'b1;
				link_speed <= gadv[eph_pkg::GADV_1000F_B] ? eph_pkg::SPD_1000 :
					(adv[eph_pkg::ADV_100_B] | adv[eph_pkg::ADV_100H_B]) ?
					eph_pkg::SPD_100 : eph_pkg::SPD_10;
			end else begin
				aneg_cnt <= aneg_cnt + 26'h0000001;
			end
		end
	end

	AST_AUTO_LINK: assert property (
		(prt_s2 && an_en && !an_restart && !link_up &&
			aneg_cnt == 26'(ANEG_CYC - 1)) |=> link_up && an_done)
		else $error("Link not raised after negotiation time");
	COV_LINK: cover property ($rose(link_up) && an_done);

	// Latched-low link bit and change interrupt; a new change beats the read
	always_ff @(posedge clk) begin
		if (rst) begin
			link_q <= 1'b0;
			stat_ll <= 1'b0;
			phy_irq_line_n <= 1'b1;
		end else begin
			link_q <= link_up;
			stat_ll <= link_up &
				(stat_ll | (rd_done && reg_a == eph_pkg::REG_STAT));
			if (link_q != link_up) begin
				phy_irq_line_n <= 1'b0;
			end else if (rd_done && reg_a == eph_pkg::REG_STAT) begin
				phy_irq_line_n <= 1'b1;
			end
		end
	end

	// Link indicator, blinking in energy-efficient mode
	always_ff @(posedge clk) begin
		if (rst || !link_up) begin
			eee_cnt <= 26'h0000000;
			led_link <= 1'b0;
		end else if (!eee_s2) begin
			eee_cnt <= 26'h0000000;
			led_link <= 1'b1;
		end else begin
			eee_cnt <= (eee_cnt == 26'(EEE_ON_CYC + EEE_OFF_CYC - 1)) ?
				26'h0000000 : eee_cnt + 26'h0000001;
			led_link <= eee_cnt < 26'(EEE_ON_CYC);
		end
	end

	AST_LINK_STEADY: assert property (
		(link_up && !eee_s2) [*2] |-> led_link)
		else $error("Link LED not steady with link");
	AST_EEE_DARK: assert property (
		(link_up && eee_s2 && eee_cnt == 26'(EEE_ON_CYC)) |=> !led_link)
		else $error("EEE blink on phase too long");
	AST_NO_LINK_DARK: assert property (
		!link_up |=> !led_link)
		else $error("Link LED lit without link");
	COV_EEE: cover property (link_up && eee_s2 && $fell(led_link));

	// Activity blinks at a fixed rate so short frames stay visible
	always_ff @(posedge clk) begin
		if (rst) begin
			act_cnt <= 26'h0000000;
			act_pend <= 1'b0;
			led_act <= 1'b0;
		end else if (act_cnt == 26'(ACT_CYC - 1)) begin
			act_cnt <= 26'h0000000;
			act_pend <= |act_s2;
			led_act <= act_pend & ~led_act;
		end else begin
			act_cnt <= act_cnt + 26'h0000001;
			act_pend <= act_pend | (|act_s2);
		end
	end

	AST_ACT_BLINK: assert property (
		$rose(led_act) |-> $past(act_pend) && $past(act_cnt) ==
			26'(ACT_CYC - 1))
		else $error("Activity LED lit without traffic or off tick");
	COV_ACT: cover property ($rose(led_act));

	// Identifier bytes in transmission order from the lowest address
	always_comb begin
		next_otp = eph_pkg::OTP_BLANK;
		for (int i = 0; i < 6; i++) begin
			if (otp_addr == eph_pkg::OTP_ID_BASE + 8'(i)) begin
				next_otp = MAC_ID[47 - 8 * i -: 8];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			otp_data <= eph_pkg::OTP_BLANK;
		end else begin
			otp_data <= next_otp;
		end
	end

	AST_OTP_FIRST_BYTE: assert property (
		(otp_addr == eph_pkg::OTP_ID_BASE) |=> otp_data == MAC_ID[47:40])
		else $error("First identifier byte not at lowest address");
endmodule

/* File: testbench/eph_mac_model.sv */
// Host-side management master model for the PHY bring-up core
`timescale 1ns/10ps
module eph_mac_model (
	// Clock
	input  wire logic clk,
	// Host GPIO
	output logic      phy_reset_line_n,
	// Management bus
	output logic      mdc,
	output logic      mdio_drv,
	output logic      mdio_en,
	input  wire logic mdio
);
	initial begin
		// Clock stands still between frames
		mdc = 1'b0;
		mdio_drv = 1'b1;
		mdio_en = 1'b0;
		phy_reset_line_n = 1'b0;
		// Hold reset until supply settles
		repeat (8) @(posedge clk);
		phy_reset_line_n <= 1'b1;
	end

	task automatic pulse_reset();
		@(posedge clk);
		phy_reset_line_n <= 1'b0;
		repeat (4) @(posedge clk);
		phy_reset_line_n <= 1'b1;
	endtask

	// Drive after fall; sample late in high phase since PHY output lags
	task automatic bit_cyc(input logic v, input logic en, output logic s);
		mdio_drv <= v;
		mdio_en <= en;
		repeat (4) @(posedge clk);
		mdc <= 1'b1;
		repeat (4) @(posedge clk);
		s = mdio;
		mdc <= 1'b0;
	endtask

	// Short preamble, MSB first, reads release TA and data
	task automatic frame(input logic [1:0] op, input logic [4:0] pa,
		input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
		logic [33:0] w;
		logic        rel;
		logic        s;
		w = {2'h3, eph_pkg::FRM_START, op, pa, ra, 2'h2, wd};
		rel = (op == eph_pkg::OP_READ);
		rd = 16'h0000;
		for (int i = 33; i >= 0; i--) begin
			bit_cyc(w[i], !(rel && i < 18), s);
			if (i < 16) begin
				rd[i] = s;
			end
		end
		mdio_en <= 1'b0;
	endtask
endmodule

/* File: testbench/eph_phy_core_bench.sv */
// Self-checking bench for the PHY bring-up core
`timescale 1ns/10ps
`define EQ(g, e) chk(16'(g), 16'(e))
module eph_phy_core_bench;
	localparam int          ANEG = 20;
	localparam int          EON  = 8;
	localparam int          EOFF = 40;
	localparam int          ACT  = 16;
	localparam logic [47:0] MID  = 48'h0200000000A5; // Arbitrary value
	logic       clk = 1'b0;
	logic       srst = 1'b1;
	logic       rst_n;
	logic       irq_n;
	logic       mdc;
	logic       mdio_drv;
	logic       mdio_en;
	logic       mdio_w;
	logic       mdio_out;
	logic       mdio_oe;
	logic       present = 1'b0;
	logic       eee = 1'b0;
	logic       rx_dv = 1'b0;
	logic       tx_en = 1'b0;
	logic       link_up;
	logic       an_done;
	logic [1:0] link_speed;
	logic       txd;
	logic       rxd;
	logic       led_link;
	logic       led_act;
	logic [7:0] otp_addr = 8'h00;
	logic [7:0] otp_data;
	int         failures = 0;
	int         checks_done = 0;

	always #25 clk = ~clk;
	// Pull-up on the shared data line
	assign mdio_w = mdio_oe ? mdio_out : (mdio_en ? mdio_drv : 1'b1);

	eph_phy_core #(.ANEG_CYC(ANEG), .EEE_ON_CYC(EON), .EEE_OFF_CYC(EOFF),
		.ACT_CYC(ACT), .MAC_ID(MID)) DUT (.clk(clk), .srst(srst),
		.phy_reset_line_n(rst_n), .phy_irq_line_n(irq_n), .mdc(mdc),
		.mdio_in(mdio_w), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
		.partner_present(present), .partner_eee(eee), .rgmii_rx_dv(rx_dv),
		.rgmii_tx_en(tx_en), .link_up(link_up), .an_done(an_done),
		.link_speed(link_speed), .rgmii_txc_delay_en(txd),
		.rgmii_rxc_delay_en(rxd), .led_link(led_link), .led_act(led_act),
		.otp_addr(otp_addr), .otp_data(otp_data));

	eph_mac_model mac (.clk(clk), .phy_reset_line_n(rst_n), .mdc(mdc),
		.mdio_drv(mdio_drv), .mdio_en(mdio_en), .mdio(mdio_w));

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic stop_test();
		$display("failures=%0d checks_done=%0d", failures, checks_done);
		if (failures == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic tmo(input int n, input int lim);
		if (n >= lim) begin
			failures++;
			stop_test();
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Cycles that the chosen LED keeps level v
	task automatic run_len(input int k, input logic v, output int n);
		n = 0;
		while (((k == 0) ? led_link : led_act) === v && n < 100) begin
			tick(1);
			n++;
		end
	endtask

	task automatic rd(input logic [4:0] pa, ra, output logic [15:0] d);
		mac.frame(eph_pkg::OP_READ, pa, ra, 16'h0000, d);
		tick(1);
	endtask

	task automatic wr(input logic [4:0] pa, ra, input logic [15:0] d);
		logic [15:0] x;
		mac.frame(eph_pkg::OP_WRITE, pa, ra, d, x);
		tick(4);
	endtask

	task automatic t_reset();
		`EQ({link_up, an_done, led_link, led_act}, 4'h0);
		`EQ({txd, rxd, irq_n, mdio_oe}, 4'hE);
	endtask

	task automatic t_otp();
		logic [7:0] e;
		for (int a = 8'h1F; a <= 8'h26; a++) begin
			otp_addr <= 8'(a);
			e = (a < 8'h20 || a > 8'h25) ? 8'hFF : MID[(37 - a) * 8 +: 8];
			tick(1);
			`EQ(otp_data, e);
		end
	endtask

	task automatic t_regs();
		logic [15:0] d;
		logic [4:0]  bad[3] = '{5'h00, 5'h02, 5'h11};
		rd(eph_pkg::PHY_ADDR, eph_pkg::REG_ADV, d);
		`EQ(d, 16'h01E1);
		rd(eph_pkg::PHY_ADDR, eph_pkg::REG_GADV, d);
		`EQ(d, 16'h0200);
		rd(eph_pkg::PHY_ADDR, eph_pkg::REG_CTRL, d);
		`EQ(d[12], 1'b1);
		rd(eph_pkg::PHY_ADDR, eph_pkg::REG_STAT, d);
		`EQ(d, 16'h7909);
		for (int i = 0; i < 3; i++) begin
			rd(bad[i], eph_pkg::REG_STAT, d);
			`EQ(d, 16'hFFFF);
		end
	endtask

	task automatic t_link();
		logic [15:0] d;
		int          n;
		present <= 1'b1;
		for (n = 0; n < 200 && link_up !== 1'b1; n++) tick(1);
		tmo(n, 200);
		`EQ(n >= ANEG, 1'b1);
		// Interrupt and LED follow link_up by one cycle
		tick(1);
		`EQ({an_done, link_speed, irq_n}, {3'h6, 1'b0});
		run_len(0, 1'b1, n);
		`EQ(n, 100);
		rd(eph_pkg::PHY_ADDR, eph_pkg::REG_STAT, d);
		`EQ(d, 16'h7929);
		`EQ(irq_n, 1'b1);
		rd(eph_pkg::PHY_ADDR, eph_pkg::REG_STAT, d);
		`EQ(d, 16'h792D);
	endtask

	task automatic t_eee();
		int n;
		eee <= 1'b1;
		run_len(0, 1'b1, n);
		run_len(0, 1'b0, n);
		run_len(0, 1'b1, n);
		`EQ(n, EON);
		run_len(0, 1'b0, n);
		`EQ(n, EOFF);
		eee <= 1'b0;
		tick(4);
	endtask

	task automatic t_act();
		int n;
		for (int k = 0; k < 2; k++) begin
			{rx_dv, tx_en} <= (k == 0) ? 2'h2 : 2'h1;
			tick(40);
			run_len(1, led_act, n);
			run_len(1, led_act, n);
			`EQ(n, ACT);
			{rx_dv, tx_en} <= 2'h0;
			tick(3 * ACT);
			`EQ(led_act, 1'b0);
		end
	endtask

	task automatic t_delay();
		logic [15:0] d;
		wr(eph_pkg::PHY_ADDR, eph_pkg::REG_DLY, 16'h0001);
		`EQ({txd, rxd}, 2'h2);
		wr(5'h02, eph_pkg::REG_DLY, 16'h0002);
		`EQ({txd, rxd}, 2'h2);
		rd(eph_pkg::PHY_ADDR, eph_pkg::REG_DLY, d);
		`EQ(d, 16'h0001);
		// Aneg off with forced 100
		wr(eph_pkg::PHY_ADDR, eph_pkg::REG_CTRL, 16'h2000);
		tick(10);
		`EQ({link_up, link_speed}, {1'b1, eph_pkg::SPD_100});
	endtask

	task automatic t_pin();
		int n;
		mac.pulse_reset();
		tick(1);
		`EQ({link_up, txd, rxd}, 3'h3);
		for (n = 0; n < 200 && link_up !== 1'b1; n++) tick(1);
		tmo(n, 200);
		`EQ(link_speed, eph_pkg::SPD_1000);
	endtask

	initial begin
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		tick(12);
		t_reset();
		t_otp();
		t_regs();
		t_link();
		t_eee();
		t_act();
		t_delay();
		t_pin();
		stop_test();
	end
endmodule
